// ### design/pcub_dev.sv
// Device end: unlock sequence and sixteen configuration registers
// Overview of operation
// - Host writes 55, AA, 36 keys in order
// - Then address/4 and its complement set index
// - Any deviating write returns sequence to idle
// - Index at even address, data next address
// - Low four index bits select register
// - Pointer write then data write stores register
// - Data write to register fifteen leaves mode
// - Registers ignore reset, default at power-up
// - Parallel and pointer bases multiplied by four
// - Register 1 bit 6 selects parallel mode
// - Register 1 bit 7 selects serial reset
// - Register B bits 7,6,4 set polarities
// - Host keeps register B bit 5 zero
// - Host programs polarities active low
// - Index address lies in 10-bit I/O region
//
// Strobed register access was left to the implementer.
module pcub_dev
   import pcub_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic pwr_on_n_i,
   pcub_if.dev bus,
   output logic cfg_mode_o,
   output logic [9:0] index_addr_o,
   output logic [9:0] parallel_base_o,
   output logic [9:0] pointer_base_o,
   output logic [9:0] serial_base_o,
   output logic pp_bidir_o,
   output logic serial_rst_ctl_o,
   output logic pol_pointer_low_o,
   output logic pol_floppy_low_o,
   output logic pol_parallel_low_o,
   output logic [127:0] cfg_regs_o
);
   typedef struct packed {
      pcub_dev_state_e st;
      logic [7:0] key;
      logic [9:0] idx_addr;
      logic [3:0] ptr;
   } pcub_ctl_s;
   typedef struct packed {
      logic [15:0][7:0] r;
   } pcub_bank_s;

   // Power-up contents of the bank, entry 15 first
   localparam pcub_bank_s BANK_RST = '{r: '{
      PCUB_RST_OTHER,
      PCUB_RST_CFGE,
      PCUB_RST_POINTER,
      PCUB_RST_CFGC,
      PCUB_RST_POLARITY,
      PCUB_RST_CFGA,
      PCUB_RST_GENSEL,
      PCUB_RST_OTHER,
      PCUB_RST_OTHER,
      PCUB_RST_PARALLEL,
      PCUB_RST_OTHER,
      PCUB_RST_SERIAL,
      PCUB_RST_OTHER,
      PCUB_RST_CFG2,
      PCUB_RST_CFG1,
      PCUB_RST_CFG0
   }};

   pcub_ctl_s c_q, c_d;
   pcub_bank_s b_q, b_d;
   logic hit_idx, hit_dat;
   logic [15:0] lane_wr;

   // Port hits only count while the bank is unlocked
   assign hit_idx = bus.wr && c_q.st == PCUB_DS_CFG &&
      bus.addr == c_q.idx_addr;
   assign hit_dat = bus.wr && c_q.st == PCUB_DS_CFG &&
      bus.addr == (c_q.idx_addr | 10'h001);

   // One write enable per bank entry; entry 15 is never stored
   for (genvar g = 0; g < 16; g++) begin : g_lane
      assign lane_wr[g] = hit_dat && c_q.ptr == 4'(g) &&
         c_q.ptr != PCUB_REG_EXIT;
   end

   always_comb begin
      c_d = c_q;
      b_d = b_q;
      // Bank entries take the data byte on their own enable
      for (int i = 0; i < 16; i++) begin
         if (lane_wr[i]) begin
            b_d.r[i] = bus.wdata;
         end
      end
      // Key sequence; any other write drops back to idle
      if (bus.wr) begin
         unique case (c_q.st)
            PCUB_DS_IDLE: begin
               if (bus.addr == PCUB_KEY_PRI_ADDR && bus.wdata == PCUB_KEY_1) begin
                  c_d.st = PCUB_DS_K1;
               end
            end
            // Fixed key bytes in order
            PCUB_DS_K1: begin
               c_d.st = (bus.addr == PCUB_KEY_SEC_ADDR && bus.wdata == PCUB_KEY_2) ?
                  PCUB_DS_K2 : PCUB_DS_IDLE;
            end
            PCUB_DS_K2: begin
               c_d.st = (bus.addr == PCUB_KEY_SEC_ADDR && bus.wdata == PCUB_KEY_3) ?
                  PCUB_DS_K3 : PCUB_DS_IDLE;
            end
            // Index address byte, then its complement
            PCUB_DS_K3: begin
               if (bus.addr == PCUB_KEY_SEC_ADDR) begin
                  c_d.st = PCUB_DS_K4;
                  c_d.key = bus.wdata;
               end else begin
                  c_d.st = PCUB_DS_IDLE;
               end
            end
            PCUB_DS_K4: begin
               if (bus.addr == PCUB_KEY_PRI_ADDR && bus.wdata == ~c_q.key) begin
                  c_d.st = PCUB_DS_CFG;
                  c_d.idx_addr = {c_q.key, 2'b00};
                  c_d.ptr = 4'h0;
               end else begin
                  c_d.st = PCUB_DS_IDLE;
               end
            end
            // Unlocked: pointer then data, exit on entry 15
            PCUB_DS_CFG: begin
               if (hit_idx) begin
                  c_d.ptr = bus.wdata[3:0];
               end else if (hit_dat && c_q.ptr == PCUB_REG_EXIT) begin
                  c_d.st = PCUB_DS_IDLE;
               end
            end
         endcase
      end
   end

   // Control state follows system reset
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         c_q <= '{st: PCUB_DS_IDLE, key: 8'h00,
            idx_addr: 10'h000, ptr: 4'h0};
      end else begin
         c_q <= c_d;
      end
   end

   // Bank is loaded with its defaults only by power-up
   always_ff @(posedge sys_clk_i or negedge pwr_on_n_i) begin
      if (!pwr_on_n_i) begin
         b_q <= BANK_RST;
      end else begin
         b_q <= b_d;
      end
   end

   // Base addresses, registered from the next bank value
   always_ff @(posedge sys_clk_i or negedge pwr_on_n_i) begin
      if (!pwr_on_n_i) begin
         parallel_base_o <= {BANK_RST.r[PCUB_REG_PARALLEL], 2'b00};
         pointer_base_o <= {BANK_RST.r[PCUB_REG_POINTER], 2'b00};
         serial_base_o <= {BANK_RST.r[PCUB_REG_SERIAL], 2'b00};
      end else begin
         parallel_base_o <= {b_d.r[PCUB_REG_PARALLEL], 2'b00};
         pointer_base_o <= {b_d.r[PCUB_REG_POINTER], 2'b00};
         serial_base_o <= {b_d.r[PCUB_REG_SERIAL], 2'b00};
      end
   end

   // Mode and polarity bits, power-up values while held
   always_ff @(posedge sys_clk_i or negedge pwr_on_n_i) begin
      if (!pwr_on_n_i) begin
         pp_bidir_o <= BANK_RST.r[PCUB_REG_CFG1][PCUB_BIT_PP_MODE];
         serial_rst_ctl_o <= BANK_RST.r[PCUB_REG_CFG1][PCUB_BIT_RST_CTL];
         pol_pointer_low_o <= BANK_RST.r[PCUB_REG_POLARITY][PCUB_BIT_POL_PTR];
         pol_floppy_low_o <= BANK_RST.r[PCUB_REG_POLARITY][PCUB_BIT_POL_FDC];
         pol_parallel_low_o <= BANK_RST.r[PCUB_REG_POLARITY][PCUB_BIT_POL_PAR];
      end else begin
         pp_bidir_o <= b_d.r[PCUB_REG_CFG1][PCUB_BIT_PP_MODE];
         serial_rst_ctl_o <= b_d.r[PCUB_REG_CFG1][PCUB_BIT_RST_CTL];
         pol_pointer_low_o <= b_d.r[PCUB_REG_POLARITY][PCUB_BIT_POL_PTR];
         pol_floppy_low_o <= b_d.r[PCUB_REG_POLARITY][PCUB_BIT_POL_FDC];
         pol_parallel_low_o <= b_d.r[PCUB_REG_POLARITY][PCUB_BIT_POL_PAR];
      end
   end

   // Whole bank mirror, shows the defaults while power-up is held
   always_ff @(posedge sys_clk_i or negedge pwr_on_n_i) begin
      if (!pwr_on_n_i) begin
         cfg_regs_o <= BANK_RST;
      end else begin
         cfg_regs_o <= b_d;
      end
   end

   // Mode flag and adopted index address
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_mode_o <= 1'b0;
         index_addr_o <= 10'h000;
      end else begin
         cfg_mode_o <= c_d.st == PCUB_DS_CFG;
         index_addr_o <= c_d.idx_addr;
      end
   end
endmodule

// ### design/pcub_host.sv
// Host end: key sequence, register writes and exit over the I/O bus
module pcub_host
   import pcub_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   pcub_if.host bus
);
   typedef enum logic [4:0] {
      PCUB_HS_IDLE = 5'b00001,
      PCUB_HS_KEY = 5'b00010,
      PCUB_HS_PTR = 5'b00100,
      PCUB_HS_DAT = 5'b01000,
      PCUB_HS_DONE = 5'b10000
   } pcub_host_state_e;
   typedef struct packed {
      pcub_host_state_e st;
      logic [2:0] step;
      logic in_cfg;
      logic [9:0] idx;
      logic [3:0] ptr;
      logic [7:0] dat;
      logic [9:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic [15:0] rdata;
   } pcub_host_s;
   pcub_host_s s_q, s_d;
   logic busy;
   logic [7:0] kb;

   assign bus.addr = s_q.addr;
   assign bus.wdata = s_q.wdata;
   assign bus.wr = s_q.wr;
   assign reg_rdata_o = s_q.rdata;

   always_comb begin
      s_d = s_q;
      s_d.wr = 1'b0;
      s_d.rdata = 16'h0000;
      busy = s_q.st != PCUB_HS_IDLE;
      kb = s_q.idx[9:2];
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            PCUB_HOST_INDEX: s_d.rdata = {6'h00, s_q.idx};
            PCUB_HOST_DATA: s_d.rdata = {4'h0, s_q.ptr, s_q.dat};
            PCUB_HOST_STATUS: s_d.rdata = {14'h0000, s_q.in_cfg, busy};
            default: s_d.rdata = 16'h0000;
         endcase
      end
      if (reg_wr_i && !busy) begin
         if (reg_addr_i == PCUB_HOST_INDEX) begin
            s_d.idx = {reg_wdata_i[9:1], 1'b0};
         end else if (reg_addr_i == PCUB_HOST_DATA) begin
            s_d.ptr = reg_wdata_i[11:8];
            s_d.dat = reg_wdata_i[7:0];
         end else if (reg_addr_i == PCUB_HOST_CTRL) begin
            if (reg_wdata_i[PCUB_CTRL_ENTER]) begin
               s_d.st = PCUB_HS_KEY;
               s_d.step = 3'h0;
            end else if (reg_wdata_i[PCUB_CTRL_WRITE]) begin
               s_d.st = PCUB_HS_PTR;
            end else if (reg_wdata_i[PCUB_CTRL_EXIT]) begin
               s_d.ptr = PCUB_REG_EXIT;
               s_d.st = PCUB_HS_PTR;
            end
         end
      end
      unique case (s_q.st)
         PCUB_HS_IDLE: begin
         end
         PCUB_HS_KEY: begin
            s_d.wr = 1'b1;
            s_d.step = s_q.step + 3'h1;
            unique case (s_q.step)
               3'h0: {s_d.addr, s_d.wdata} = {PCUB_KEY_PRI_ADDR, PCUB_KEY_1};
               3'h1: {s_d.addr, s_d.wdata} = {PCUB_KEY_SEC_ADDR, PCUB_KEY_2};
               3'h2: {s_d.addr, s_d.wdata} = {PCUB_KEY_SEC_ADDR, PCUB_KEY_3};
               3'h3: {s_d.addr, s_d.wdata} = {PCUB_KEY_SEC_ADDR, kb};
               default: begin
                  {s_d.addr, s_d.wdata} = {PCUB_KEY_PRI_ADDR, ~kb};
                  s_d.st = PCUB_HS_DONE;
                  s_d.in_cfg = 1'b1;
               end
            endcase
         end
         PCUB_HS_PTR: begin
            s_d.wr = 1'b1;
            s_d.addr = s_q.idx;
            s_d.wdata = {4'h0, s_q.ptr};
            s_d.st = PCUB_HS_DAT;
         end
         PCUB_HS_DAT: begin
            s_d.wr = 1'b1;
            s_d.addr = s_q.idx | 10'h001;
            if (s_q.ptr == PCUB_REG_POLARITY) begin
               s_d.wdata = (s_q.dat | PCUB_POL_ACTIVE_LOW) &
                  ~(8'h01 << PCUB_BIT_POL_SER);
            end else begin
               s_d.wdata = s_q.dat;
            end
            if (s_q.ptr == PCUB_REG_EXIT) begin
               s_d.in_cfg = 1'b0;
            end
            s_d.st = PCUB_HS_DONE;
         end
         PCUB_HS_DONE: begin
            s_d.st = PCUB_HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '{st: PCUB_HS_IDLE, step: 3'h0, in_cfg: 1'b0, idx: PCUB_RST_HOST_INDEX,
            ptr: 4'h0, dat: 8'h00, addr: 10'h000, wdata: 8'h00, wr: 1'b0,
            rdata: 16'h0000};
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ### design/pcub_if.sv
// Interface of the 8-bit I/O write bus between host and device
interface pcub_if;
   logic [9:0] addr;
   logic [7:0] wdata;
   logic wr;
   modport dev (input addr, input wdata, input wr);
   modport host (output addr, output wdata, output wr);
endinterface

// ### design/pcub_pkg.sv
// Package of constants and types for the configuration unlock bank
package pcub_pkg;
   localparam int unsigned PCUB_AW = 10;
   localparam logic [9:0] PCUB_KEY_PRI_ADDR = 10'h2fa;
   localparam logic [9:0] PCUB_KEY_SEC_ADDR = 10'h3fa;
   localparam logic [7:0] PCUB_KEY_1 = 8'h55;
   localparam logic [7:0] PCUB_KEY_2 = 8'haa;
   localparam logic [7:0] PCUB_KEY_3 = 8'h36;
   localparam int unsigned PCUB_ADDR_SHIFT = 2;
   localparam logic [3:0] PCUB_REG_CFG0 = 4'h0;
   localparam logic [3:0] PCUB_REG_CFG1 = 4'h1;
   localparam logic [3:0] PCUB_REG_CFG2 = 4'h2;
   localparam logic [3:0] PCUB_REG_SERIAL = 4'h4;
   localparam logic [3:0] PCUB_REG_PARALLEL = 4'h6;
   localparam logic [3:0] PCUB_REG_GENSEL = 4'h9;
   localparam logic [3:0] PCUB_REG_CFGA = 4'ha;
   localparam logic [3:0] PCUB_REG_POLARITY = 4'hb;
   localparam logic [3:0] PCUB_REG_CFGC = 4'hc;
   localparam logic [3:0] PCUB_REG_POINTER = 4'hd;
   localparam logic [3:0] PCUB_REG_CFGE = 4'he;
   localparam logic [3:0] PCUB_REG_EXIT = 4'hf;
   localparam logic [7:0] PCUB_RST_CFG0 = 8'h0c;
   localparam logic [7:0] PCUB_RST_CFG1 = 8'h00;
   localparam logic [7:0] PCUB_RST_CFG2 = 8'h00;
   localparam logic [7:0] PCUB_RST_SERIAL = 8'hfe;
   localparam logic [7:0] PCUB_RST_PARALLEL = 8'h9e;
   localparam logic [7:0] PCUB_RST_GENSEL = 8'hb0;
   localparam logic [7:0] PCUB_RST_CFGA = 8'h00;
   localparam logic [7:0] PCUB_RST_POLARITY = 8'h00;
   localparam logic [7:0] PCUB_RST_CFGC = 8'ha0;
   localparam logic [7:0] PCUB_RST_POINTER = 8'h00;
   localparam logic [7:0] PCUB_RST_CFGE = 8'h00;
   localparam logic [7:0] PCUB_RST_OTHER = 8'h00;
   localparam int unsigned PCUB_BIT_PP_MODE = 6;
   localparam int unsigned PCUB_BIT_RST_CTL = 7;
   localparam int unsigned PCUB_BIT_POL_PTR = 7;
   localparam int unsigned PCUB_BIT_POL_FDC = 6;
   localparam int unsigned PCUB_BIT_POL_SER = 5;
   localparam int unsigned PCUB_BIT_POL_PAR = 4;
   localparam logic [7:0] PCUB_POL_ACTIVE_LOW = 8'hd0;
   // Host command port registers
   localparam logic [3:0] PCUB_HOST_CTRL = 4'h0;
   localparam logic [3:0] PCUB_HOST_INDEX = 4'h1;
   localparam logic [3:0] PCUB_HOST_DATA = 4'h2;
   localparam logic [3:0] PCUB_HOST_STATUS = 4'h3;
   localparam int unsigned PCUB_CTRL_ENTER = 0;
   localparam int unsigned PCUB_CTRL_WRITE = 1;
   localparam int unsigned PCUB_CTRL_EXIT = 2;
   localparam logic [9:0] PCUB_RST_HOST_INDEX = 10'h390;
   typedef enum logic [5:0] {
      PCUB_DS_IDLE = 6'b000001,
      PCUB_DS_K1 = 6'b000010,
      PCUB_DS_K2 = 6'b000100,
      PCUB_DS_K3 = 6'b001000,
      PCUB_DS_K4 = 6'b010000,
      PCUB_DS_CFG = 6'b100000
   } pcub_dev_state_e;
endpackage

// ### tb/pcub_props.sv
// Assertions on the host to device write bus and the bank outputs
module pcub_props
   import pcub_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic pwr_on_n_i,
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic cfg_mode_o,
   input wire logic [9:0] index_addr_o,
   input wire logic [9:0] parallel_base_o,
   input wire logic [9:0] pointer_base_o,
   input wire logic pp_bidir_o,
   input wire logic serial_rst_ctl_o,
   input wire logic pol_pointer_low_o,
   input wire logic pol_floppy_low_o,
   input wire logic pol_parallel_low_o,
   input wire logic [127:0] cfg_regs_o
);
   logic [3:0] ptr_q;
   logic dat_w;
   assign dat_w = cfg_mode_o && wr && addr == (index_addr_o | 10'h001);
   // Pointer as the device should hold it
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) ptr_q <= 4'h0;
      else if (!cfg_mode_o) ptr_q <= 4'h0;
      else if (wr && addr == index_addr_o) ptr_q <= wdata[3:0];
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i || !pwr_on_n_i);
   entry_seq_a: assert property (
      (!cfg_mode_o && wr && addr == 10'h2fa && wdata == 8'h55)
      ##1 (wr && addr == 10'h3fa && wdata == 8'haa) ##1 (wr && addr == 10'h3fa && wdata == 8'h36)
      ##1 (wr && addr == 10'h3fa) ##1 (wr && addr == 10'h2fa && wdata == ~$past(wdata))
      |=> cfg_mode_o && index_addr_o == {$past(wdata, 2), 2'b00}) else $error("entry missed");
   bad_addr_a: assert property (!cfg_mode_o && wr && addr != 10'h2fa && addr != 10'h3fa
      |=> !cfg_mode_o [*5]) else $error("entry after stray write");
   exit_mode_a: assert property (dat_w && ptr_q == 4'hf |=> !cfg_mode_o)
      else $error("mode kept after exit");
   data_store_a: assert property (dat_w && ptr_q != 4'hf
      |=> cfg_regs_o[8*ptr_q +: 8] == $past(wdata)) else $error("byte not stored");
   ignore_out_a: assert property (!cfg_mode_o |=> $stable(cfg_regs_o))
      else $error("bank changed outside mode");
   par_base_a: assert property ($past(pwr_on_n_i) |->
      {parallel_base_o, pointer_base_o} == {cfg_regs_o[55:48], 2'b00, cfg_regs_o[111:104], 2'b00})
      else $error("base address wrong");
   pp_mode_a: assert property ($past(pwr_on_n_i) |-> pp_bidir_o == cfg_regs_o[14])
      else $error("parallel mode wrong");
   rst_ctl_a: assert property ($past(pwr_on_n_i) |-> serial_rst_ctl_o == cfg_regs_o[15])
      else $error("reset control wrong");
   pol_bits_a: assert property ($past(pwr_on_n_i) |->
      {pol_pointer_low_o, pol_floppy_low_o, pol_parallel_low_o} == {cfg_regs_o[95:94], cfg_regs_o[92]})
      else $error("polarity wrong");
endmodule

// ### tb/tb.sv
// Testbench: host and device ends joined over the write bus
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i, rst_n_i, pwr_on_n_i, reg_wr_i, reg_rd_i, cfg_mode_o, cfg2, pp_bidir_o;
   logic serial_rst_ctl_o, pol_pointer_low_o, pol_floppy_low_o, pol_parallel_low_o;
   logic rd_d = 1'b0;
   logic [3:0] reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o;
   logic [9:0] index_addr_o, idx2, parallel_base_o, pointer_base_o, serial_base_o, idx;
   logic [127:0] cfg_regs_o;
   logic [7:0] m[16], d;
   logic [15:0] exp_q[$];
   logic [17:0] bs[11] = '{18'h2fa55, 18'h3faaa, 18'h3fa00, 18'h3fa36, 18'h3fae4, 18'h2fa1b,
      18'h2fa55, 18'h3faaa, 18'h3fa36, 18'h3fae4, 18'h2fa1b};
   int error_cnt = 0, checks_done = 0;
   pcub_if bus();
   pcub_if bad_bus();
   pcub_host u_pcub_host (.*);
   pcub_dev u_pcub_dev (.*);
   pcub_dev u_pcub_dev2 (.sys_clk_i, .rst_n_i, .pwr_on_n_i, .bus(bad_bus), .cfg_mode_o(cfg2),
      .index_addr_o(idx2), .parallel_base_o(), .pointer_base_o(), .serial_base_o(),
      .pp_bidir_o(), .serial_rst_ctl_o(), .pol_pointer_low_o(), .pol_floppy_low_o(),
      .pol_parallel_low_o(), .cfg_regs_o());
   pcub_props u_pcub_props (.*, .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr));
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input logic [127:0] s, input logic [127:0] e);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("FAIL %0t got %h expected %h", $time, s, e);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Read data stands in the cycle after the strobe
   always @(posedge sys_clk_i) rd_d <= reg_rd_i;
   always @(negedge sys_clk_i) if (rd_d) chk(reg_rdata_o, exp_q.pop_front());
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
   endtask
   task automatic bw(input logic [17:0] w);
      @(posedge sys_clk_i);
      {bad_bus.addr, bad_bus.wdata} <= w;
      bad_bus.wr <= 1'b1;
      @(posedge sys_clk_i);
      bad_bus.wr <= 1'b0;
   endtask
   task automatic cfgw(input logic [3:0] p, input logic [7:0] v);
      wr(4'h2, {4'h0, p, v});
      wr(4'h0, 16'h0002);
      repeat (5) @(posedge sys_clk_i);
   endtask
   task automatic enter;
      wr(4'h0, 16'h0001);
      repeat (7) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask
   task dflt;
      m = '{8'h0c, 8'h00, 8'h00, 8'h00, 8'hfe, 8'h00, 8'h9e, 8'h00,
         8'h00, 8'hb0, 8'h00, 8'h00, 8'ha0, 8'h00, 8'h00, 8'h00};
   endtask
   task automatic dchk;
      logic [127:0] p;
      for (int i = 0; i < 16; i++) p[8*i +: 8] = m[i];
      @(negedge sys_clk_i);
      chk(cfg_regs_o, p);
      chk({parallel_base_o, pointer_base_o}, {m[6], 2'b00, m[13], 2'b00});
      chk(serial_base_o, {m[4], 2'b00});
      chk({serial_rst_ctl_o, pp_bidir_o}, m[1][7:6]);
      chk({pol_pointer_low_o, pol_floppy_low_o, pol_parallel_low_o}, {m[11][7:6], m[11][4]});
   endtask
   // Run is a few hundred cycles, so this leaves a wide margin
   initial begin
      #40000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'h020c));
      {rst_n_i, pwr_on_n_i, reg_wr_i, reg_rd_i} = '0;
      reg_addr_i = 4'h0;
      reg_wdata_i = 16'h0000;
      bad_bus.addr = 10'h000;
      bad_bus.wdata = 8'h00;
      bad_bus.wr = 1'b0;
      dflt();
      repeat (2) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      pwr_on_n_i <= 1'b1;
      @(posedge sys_clk_i);
      dchk();
      rd(4'h3, 16'h0000);
      cfgw(4'h6, 8'($urandom));
      dchk();
      $display("test defaults and locked bank done");
      idx = {8'($urandom), 2'b00};
      wr(4'h1, {6'h00, idx});
      enter();
      chk({cfg_mode_o, index_addr_o}, {1'b1, idx});
      rd(4'h3, 16'h0002);
      for (int p = 0; p < 15; p++) begin
         d = 8'($urandom);
         cfgw(4'(p), d);
         m[p] = (p == 11) ? ((d | 8'hd0) & 8'hdf) : d;
         dchk();
      end
      $display("test register writes done");
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      dchk();
      enter();
      chk(index_addr_o, 10'h390);
      wr(4'h2, {8'h0f, 8'($urandom)});
      wr(4'h0, 16'h0004);
      repeat (5) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk(cfg_mode_o, 1'b0);
      dchk();
      rd(4'h3, 16'h0000);
      rd(4'h9, 16'h0000);
      cfgw(4'h1, ~m[1]);
      dchk();
      $display("test reset and exit done");
      for (int i = 0; i < 11; i++) begin
         bw(bs[i]);
         @(negedge sys_clk_i);
         if (i == 5) chk(cfg2, 1'b0);
      end
      chk({cfg2, idx2}, {1'b1, 10'h390});
      $display("test broken key sequence done");
      @(posedge sys_clk_i);
      pwr_on_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      pwr_on_n_i <= 1'b1;
      dflt();
      @(posedge sys_clk_i);
      dchk();
      $display("test power-up done");
      repeat (3) @(posedge sys_clk_i);
      wrap_up();
   end
endmodule
